// ---- rtl/scb_pkg.sv ----
package scb_pkg;
	// Register byte offsets
	localparam logic [3:0] SCB_OFF_CFG3   = 4'h0;
	localparam logic [3:0] SCB_OFF_CTRL   = 4'h4;
	localparam logic [3:0] SCB_OFF_EBIA   = 4'h8;
	localparam logic [3:0] SCB_OFF_UNLOCK = 4'hc;
	// Unlock keys, written in order
	localparam logic [31:0] SCB_KEY1 = 32'haa99_6655;
	localparam logic [31:0] SCB_KEY2 = 32'h5566_99aa;
	// Configuration word fields
	localparam int SCB_C3_USBID = 30;
	localparam int SCB_C3_IO1W  = 29;
	localparam int SCB_C3_PMD1W = 28;
	localparam int SCB_C3_PG1W  = 27;
	localparam int SCB_C3_ETHIO = 25;
	localparam int SCB_C3_MII   = 24;
	// Reserved configuration bits read as one
	localparam logic [31:0] SCB_C3_RSVD = 32'h84ff_0000;
	// Control register fields
	localparam int SCB_CT_DMA_SRAM_PRIORITY = 25;
	localparam int SCB_CT_CPU_IRQ_SRAM_PRIORITY = 24;
	localparam int SCB_CT_ICALT  = 17;
	localparam int SCB_CT_OCALT  = 16;
	localparam int SCB_CT_IOLK   = 13;
	localparam int SCB_CT_PMDLK  = 12;
	localparam int SCB_CT_PGLK   = 11;
	localparam int SCB_CT_USBSS  = 8;
	localparam int SCB_CT_ECC_LO = 4;
	localparam int SCB_CT_JTAG   = 3;
	localparam int SCB_CT_TRACE  = 2;
	localparam int SCB_CT_TDO    = 0;
	localparam logic [31:0] SCB_CT_MASK  = 32'h0303_393d;
	localparam logic [31:0] SCB_CT_RESET = 32'h0000_0039;
	localparam logic [1:0]  SCB_ECC_OPEN = 2'h3;
	// Address pin register
	localparam logic [31:0] SCB_EBIA_MASK = 32'h80ff_ffff;
	// Unlock sequencer states
	typedef enum logic [1:0] {
		SCB_UL_IDLE = 2'b00,
		SCB_UL_KEY1 = 2'b01,
		SCB_UL_OPEN = 2'b11
	} scb_ul_t;
	// Decoded system controls
	typedef struct packed {
		logic        dma_sram_priority;
		logic        cpu_irq_sram_priority;
		logic        capture_alt_timebase;
		logic        compare_alt_timebase;
		logic        pin_select_lock;
		logic        module_disable_lock;
		logic        perm_group_lock;
		logic        usb_phy_clk_stop;
		logic [1:0]  flash_ecc_mode;
		logic        ecc_word_write_block;
		logic        jtag_port_enable;
		logic        trace_output_enable;
		logic        two_wire_tdo_use;
	} scb_ctl_t;
	// Decoded pin ownership
	typedef struct packed {
		logic        usb_id_to_usb;
		logic        eth_pin_set_select;
		logic        eth_full_media_if_select;
		logic        ext_bus_shared_pin_enable;
		logic [23:0] ext_bus_addr_pin_enable;
	} scb_pins_t;
endpackage

// ---- rtl/scb_bank.sv ----
// Function
// - USB id pin to USB unless disabled
// - Pin-select one-way limits lock to once
// - Module-disable one-way limits lock once
// - Perm-group one-way limits lock once
// - Ethernet pin set select bit
// - Full or reduced media interface select
// - Hold 16-bit user identifier readable
// - Protected writes need unlock sequence
// - DMA high SRAM priority bit
// - CPU interrupt SRAM priority bit
// - Capture alternate timebase select
// - Compare alternate timebase select
// - Pin-select lock blocks writes
// - Module-disable lock blocks writes
// - Perm-group lock blocks writes
// - USB PHY clock stops in sleep
// - Flash ECC mode encoding and lock
// - JTAG port enable bit
// - Trace outputs and clock enable
// - Two-wire JTAG uses TDO
// - Control reset value ECC 11, JTAG, TDO
// - Shared pin enable for external bus
// - Address pin enables, ignored if disabled
`timescale 1ns/100ps
`default_nettype none
module scb_bank
	import scb_pkg::*;
#(
	parameter logic [31:0] NV_CFG3_DEFAULT = 32'hffff_ffff
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [1:0]       avs_response,
	input  wire logic [31:0] nv_cfg3,
	input  wire logic        usb_module_disable,
	input  wire logic        ext_bus_module_disable,
	input  wire logic        sleep_active,
	input  wire logic        pin_select_wr_req,
	input  wire logic        module_disable_wr_req,
	input  wire logic        perm_group_wr_req,
	output logic             pin_select_wr_ok,
	output logic             module_disable_wr_ok,
	output logic             perm_group_wr_ok,
	output logic [15:0]      user_identifier,
	output scb_ctl_t         ctl,
	output scb_pins_t        pins
);
	// Configuration word image
	logic [31:0] cfg3_r;
	// Strap load pending after reset
	logic        cfg3_load_r;
	// Control register image
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	// Address pin register image
	logic [31:0] ebia_r;
	// Unlock sequencer
	scb_ul_t     ul_r;
	// Locks once set under one-way options
	logic        io_once_r;
	logic        pmd_once_r;
	logic        pg_once_r;
	// Answer phase of the bus slave
	logic        ack_r;
	logic [31:0] rdata_r;
	logic        err_r;
	logic [31:0] wmask;
	logic        acc;
	logic        wr_go;

	// Full-word byte mask from byte enables
	always_comb begin
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	end

	// One wait cycle per access, answer on second cycle
	assign acc             = (avs_read | avs_write) & ~ack_r;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_go           = avs_write & ack_r;

	// Answer flag
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc;
		end
	end

	// nonvolatile load
	// Configuration word caught one cycle after reset release
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cfg3_r      <= NV_CFG3_DEFAULT;
			cfg3_load_r <= 1'b1;
		end else if (cfg3_load_r) begin
			cfg3_r      <= nv_cfg3 | SCB_C3_RSVD;
			cfg3_load_r <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ul_r <= SCB_UL_IDLE;
		end else if (wr_go && avs_address == SCB_OFF_UNLOCK) begin
			// Key pair opens, anything else closes
			if (avs_writedata == SCB_KEY1) begin
				ul_r <= SCB_UL_KEY1;
			end else if (avs_writedata == SCB_KEY2 &&
				ul_r == SCB_UL_KEY1) begin
				ul_r <= SCB_UL_OPEN;
			end else begin
				ul_r <= SCB_UL_IDLE;
			end
		end else if (wr_go && avs_address == SCB_OFF_CTRL) begin
			// Each protected write uses up the unlock
			ul_r <= SCB_UL_IDLE;
		end else begin
			case (ul_r)
				SCB_UL_IDLE: ul_r <= SCB_UL_IDLE;
				SCB_UL_KEY1: ul_r <= SCB_UL_KEY1;
				SCB_UL_OPEN: ul_r <= SCB_UL_OPEN;
				default:     ul_r <= SCB_UL_IDLE;
			endcase
		end
	end

	// Next control value, honouring locks
	always_comb begin
		ctrl_nxt = (ctrl_r & ~wmask) | (avs_writedata & wmask);
		ctrl_nxt = ctrl_nxt & SCB_CT_MASK;
		if (io_once_r) begin
			ctrl_nxt[SCB_CT_IOLK] = 1'b1;
		end
		if (pmd_once_r) begin
			ctrl_nxt[SCB_CT_PMDLK] = 1'b1;
		end
		if (pg_once_r) begin
			ctrl_nxt[SCB_CT_PGLK] = 1'b1;
		end
		if (ctrl_r[SCB_CT_ECC_LO +: 2] != SCB_ECC_OPEN) begin
			ctrl_nxt[SCB_CT_ECC_LO +: 2] = ctrl_r[SCB_CT_ECC_LO +: 2];
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ctrl_r <= SCB_CT_RESET;
		end else if (wr_go && avs_address == SCB_OFF_CTRL &&
			ul_r == SCB_UL_OPEN) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			io_once_r  <= 1'b0;
			pmd_once_r <= 1'b0;
			pg_once_r  <= 1'b0;
		end else begin
			if (cfg3_r[SCB_C3_IO1W] && ctrl_r[SCB_CT_IOLK]) begin
				io_once_r <= 1'b1;
			end
			if (cfg3_r[SCB_C3_PMD1W] && ctrl_r[SCB_CT_PMDLK]) begin
				pmd_once_r <= 1'b1;
			end
			if (cfg3_r[SCB_C3_PG1W] && ctrl_r[SCB_CT_PGLK]) begin
				pg_once_r <= 1'b1;
			end
		end
	end

	// Address pin register, no unlock needed
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ebia_r <= 32'h0000_0000;
		end else if (wr_go && avs_address == SCB_OFF_EBIA) begin
			ebia_r <= ((ebia_r & ~wmask) | (avs_writedata & wmask))
				& SCB_EBIA_MASK;
		end
	end

	// Read data and unmapped-address answer
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rdata_r <= 32'h0000_0000;
			err_r   <= 1'b0;
		end else if (acc) begin
			err_r <= 1'b0;
			case (avs_address)
				SCB_OFF_CFG3:   rdata_r <= cfg3_r;
				SCB_OFF_CTRL:   rdata_r <= ctrl_r;
				SCB_OFF_EBIA:   rdata_r <= ebia_r;
				SCB_OFF_UNLOCK: rdata_r <= 32'h0000_0000;
				default: begin
					rdata_r <= 32'h0000_0000;
					err_r   <= 1'b1;
				end
			endcase
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_response = err_r ? 2'h2 : 2'h0;

	assign pin_select_wr_ok     = pin_select_wr_req & ~ctrl_r[SCB_CT_IOLK];
	assign module_disable_wr_ok = module_disable_wr_req &
		~ctrl_r[SCB_CT_PMDLK];
	assign perm_group_wr_ok     = perm_group_wr_req & ~ctrl_r[SCB_CT_PGLK];

	assign user_identifier = cfg3_r[15:0];

	// Decoded control outputs
	always_comb begin
		ctl.dma_sram_priority     = ctrl_r[SCB_CT_DMA_SRAM_PRIORITY];
		ctl.cpu_irq_sram_priority = ctrl_r[SCB_CT_CPU_IRQ_SRAM_PRIORITY];
		ctl.capture_alt_timebase  = ctrl_r[SCB_CT_ICALT];
		ctl.compare_alt_timebase  = ctrl_r[SCB_CT_OCALT];
		ctl.pin_select_lock       = ctrl_r[SCB_CT_IOLK];
		ctl.module_disable_lock   = ctrl_r[SCB_CT_PMDLK];
		ctl.perm_group_lock       = ctrl_r[SCB_CT_PGLK];
		ctl.usb_phy_clk_stop      = ctrl_r[SCB_CT_USBSS] & sleep_active;
		ctl.flash_ecc_mode        = ctrl_r[SCB_CT_ECC_LO +: 2];
		ctl.ecc_word_write_block  = ctrl_r[SCB_CT_ECC_LO +: 2] == 2'h0;
		ctl.jtag_port_enable      = ctrl_r[SCB_CT_JTAG];
		ctl.trace_output_enable   = ctrl_r[SCB_CT_TRACE];
		ctl.two_wire_tdo_use      = ctrl_r[SCB_CT_TDO];
	end

	// Pin ownership outputs
	always_comb begin
		pins.usb_id_to_usb = cfg3_r[SCB_C3_USBID] & ~usb_module_disable;
		pins.eth_pin_set_select = cfg3_r[SCB_C3_ETHIO];
		pins.eth_full_media_if_select = cfg3_r[SCB_C3_MII];
		pins.ext_bus_shared_pin_enable = ebia_r[31] &
			~ext_bus_module_disable;
		pins.ext_bus_addr_pin_enable = ebia_r[23:0] &
			{24{~ext_bus_module_disable}};
	end
endmodule
`default_nettype wire

// ---- sim/scb_bank_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module scb_bank_sva
	import scb_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        usb_module_disable,
	input wire logic        ext_bus_module_disable,
	input wire logic        sleep_active,
	input wire logic        pin_select_wr_req,
	input wire logic        module_disable_wr_req,
	input wire logic        perm_group_wr_req,
	input wire logic        pin_select_wr_ok,
	input wire logic        module_disable_wr_ok,
	input wire logic        perm_group_wr_ok,
	input wire logic [15:0] user_identifier,
	input wire scb_ctl_t    ctl,
	input wire scb_pins_t   pins
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	property p_ps;
		pin_select_wr_ok == (pin_select_wr_req && !ctl.pin_select_lock);
	endproperty
	a_ps: assert property (p_ps) else $error("pin select grant");
	property p_md;
		module_disable_wr_ok == (module_disable_wr_req && !ctl.module_disable_lock);
	endproperty
	a_md: assert property (p_md) else $error("module grant");
	property p_pg;
		perm_group_wr_ok == (perm_group_wr_req && !ctl.perm_group_lock);
	endproperty
	a_pg: assert property (p_pg) else $error("group grant");
	property p_usb;
		usb_module_disable |-> !pins.usb_id_to_usb;
	endproperty
	a_usb: assert property (p_usb) else $error("usb id pin");
	property p_ebi;
		ext_bus_module_disable |-> pins.ext_bus_addr_pin_enable == 24'h0;
	endproperty
	a_ebi: assert property (p_ebi) else $error("address pins");
	property p_slp;
		!sleep_active |-> !ctl.usb_phy_clk_stop;
	endproperty
	a_slp: assert property (p_slp) else $error("phy clock stop");
	property p_ecc;
		ctl.ecc_word_write_block == (ctl.flash_ecc_mode == 2'h0);
	endproperty
	a_ecc: assert property (p_ecc) else $error("ecc word block");
	property p_uid;
		$past(rstn, 2) |-> $stable(user_identifier);
	endproperty
	a_uid: assert property (p_uid) else $error("user id moved");
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("no answer");
endmodule
bind scb_bank scb_bank_sva u_sva (.clock, .rstn, .avs_read, .avs_write,
	.avs_waitrequest, .usb_module_disable, .ext_bus_module_disable,
	.sleep_active, .pin_select_wr_req, .module_disable_wr_req,
	.perm_group_wr_req, .pin_select_wr_ok, .module_disable_wr_ok,
	.perm_group_wr_ok, .user_identifier, .ctl, .pins);
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	import scb_pkg::*;
	logic        clock = 0, rstn = 0, rd_r = 0, wr_r = 0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wd = 32'h0, avs_readdata, rd;
	logic        wq, umd = 0, emd = 0, slp = 0;
	logic [1:0]  avs_response, rsp;
	logic        ps_req = 0, md_req = 0, pg_req = 0, ps_ok, md_ok, pg_ok;
	logic [15:0] uid;
	scb_ctl_t    ctl;
	scb_pins_t   pins;
	int          miscompares = 0, num_checks = 0;
	// Free-running 100 MHz clock
	always #5 clock = ~clock;
	// reserved config bits programmed as ones
	scb_bank DUT (.clock, .rstn, .avs_address(adr), .avs_read(rd_r),
		.avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata, .avs_waitrequest(wq), .avs_response,
		.nv_cfg3(32'he5ff_a5c3), .usb_module_disable(umd),
		.ext_bus_module_disable(emd), .sleep_active(slp),
		.pin_select_wr_req(ps_req), .module_disable_wr_req(md_req),
		.perm_group_wr_req(pg_req), .pin_select_wr_ok(ps_ok),
		.module_disable_wr_ok(md_ok), .perm_group_wr_ok(pg_ok),
		.user_identifier(uid), .ctl, .pins);
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One bus access, held until waitrequest is low
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		rd_r <= !w;
		wr_r <= w;
		adr <= a;
		wd <= d;
		#1;
		while (wq !== 1'b0 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n == 20) begin
			miscompares++;
			tally_and_finish();
		end
		rd = avs_readdata;
		rsp = avs_response;
		@(posedge clock);
	endtask
	// Drop the request for one cycle
	task automatic idle;
		rd_r <= 1'b0;
		wr_r <= 1'b0;
		@(posedge clock);
	endtask
	// Key pair, then a control write and read back
	task automatic wctl(input logic [31:0] d);
		acc(1, SCB_OFF_UNLOCK, SCB_KEY1);
		acc(1, SCB_OFF_UNLOCK, SCB_KEY2);
		acc(1, SCB_OFF_CTRL, d);
		acc(0, SCB_OFF_CTRL, 32'h0);
		idle();
	endtask
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		acc(1, SCB_OFF_CFG3, 32'h0);
		acc(0, SCB_OFF_CFG3, 32'h0);
		chk(rd, 32'he5ff_a5c3);
		acc(0, SCB_OFF_CTRL, 32'h0);
		chk(rd, 32'h0000_0039);
		acc(0, SCB_OFF_EBIA, 32'h0);
		chk(rd, 32'h0);
		acc(0, 4'h2, 32'h0);
		chk(rsp, 2'h2);
		idle();
		chk(uid, 16'ha5c3);
		chk({pins.eth_pin_set_select, pins.eth_full_media_if_select}, 1);
		chk(pins.usb_id_to_usb, 1);
		umd <= 1'b1;
		@(posedge clock);
		chk(pins.usb_id_to_usb, 0);
		$display("test config word done");
		acc(1, SCB_OFF_CTRL, 32'h0303_3934);
		acc(0, SCB_OFF_CTRL, 32'h0);
		chk(rd, 32'h0000_0039);
		wctl(32'h0303_3934);
		chk(rd, 32'h0303_3934);
		acc(1, SCB_OFF_CTRL, 32'h0);
		acc(0, SCB_OFF_CTRL, 32'h0);
		chk(rd, 32'h0303_3934);
		idle();
		chk(ctl, 32'h3fb2);
		ps_req <= 1'b1;
		md_req <= 1'b1;
		pg_req <= 1'b1;
		slp <= 1'b1;
		@(posedge clock);
		chk({ps_ok, md_ok, pg_ok, ctl.usb_phy_clk_stop}, 1);
		$display("test unlock done");
		wctl(32'h0000_0030);
		chk(rd, 32'h0000_2030);
		chk({ps_ok, md_ok, pg_ok}, 3);
		wctl(32'h0000_2000);
		chk(rd, 32'h0000_2000);
		wctl(32'h0000_2010);
		chk(rd, 32'h0000_2000);
		chk(ctl.ecc_word_write_block, 1);
		$display("test locks done");
		acc(1, SCB_OFF_EBIA, 32'hffff_ffff);
		acc(0, SCB_OFF_EBIA, 32'h0);
		chk(rd, 32'h80ff_ffff);
		idle();
		chk(pins[24:0], 32'h1ff_ffff);
		emd <= 1'b1;
		@(posedge clock);
		chk(pins.ext_bus_addr_pin_enable, 0);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		acc(0, SCB_OFF_CTRL, 32'h0);
		idle();
		chk(rd, 32'h0000_0039);
		$display("test bus and reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
